// ### rtl/amf_consts.svh
// constants for the automatic measurement, filter and result fifo core
`ifndef AMF_CONSTS_SVH
`define AMF_CONSTS_SVH
// -----------------------------------------------------------------
// operation word layout and reset
// -----------------------------------------------------------------
`define AMF_OP_RESET       16'h0000
`define AMF_OP_THR_HI      12
`define AMF_OP_THR_LO      8
`define AMF_OP_MODE_HI     7
`define AMF_OP_MODE_LO     6
`define AMF_OP_DLY_HI      3
`define AMF_OP_DLY_LO      0
`define AMF_MODE_OFF       2'h0
`define AMF_MODE_FULL      2'h1
// -----------------------------------------------------------------
// channel configuration word fields
// -----------------------------------------------------------------
`define AMF_CFG_RATIO_HI   10
`define AMF_CFG_RATIO_LO   8
`define AMF_CFG_FILT_HI    7
`define AMF_CFG_FILT_LO    5
// -----------------------------------------------------------------
// fifo size and sticky flag positions
// -----------------------------------------------------------------
`define AMF_FIFO_DEPTH     6'h20
`define AMF_FIFO_UPD_MAX   6'h1F
`define AMF_FLAG_FULL      2
`define AMF_FLAG_THR       1
// -----------------------------------------------------------------
// timing: clock, oscillator, busy flash, delay codes in ms
// -----------------------------------------------------------------
`define AMF_CLK_NS         20
`define AMF_OSC_PERIOD_NS  160
`define AMF_BUSY_NS        100
`define AMF_BUSY_CYC       ((`AMF_BUSY_NS + `AMF_CLK_NS - 1) / `AMF_CLK_NS)
`define AMF_DLY1_MS        5
`define AMF_DLY2_MS        10
`define AMF_DLY3_MS        20
`define AMF_DLY4_MS        50
`define AMF_DLY5_MS        100
`define AMF_DLY6_MS        200
`define AMF_DLY7_MS        500
`define AMF_DLY8_MS        1000
`define AMF_DLY9_MS        2000
`define AMF_DLY10_MS       5000
`define AMF_DLY11_MS       10000
`define AMF_DLY12_MS       20000
`define AMF_DLY_MAX_MS     60000
`endif

// ### rtl/amf_pkg.sv
// types shared by the measurement core and its users
package amf_pkg;
  // scheduler states, one-hot
  typedef enum logic [2:0] {
    AMF_IDLE = 3'b001,
    AMF_CONV = 3'b010,
    AMF_SKIP = 3'b100
  } amf_state_e;

  // operation control word
  typedef struct packed {
    logic [2:0] spare_hi;
    logic [4:0] thr;
    logic [1:0] mode;
    logic [1:0] spare_mid;
    logic [3:0] delay;
  } amf_op_s;

  // one fifo entry
  typedef struct packed {
    logic [23:0] temp;
    logic [23:0] pres;
  } amf_pair_s;

  // register state of the core, apart from the fifo memory and read port
  typedef struct packed {
    amf_op_s    op;
    logic [15:0] cfg_p;
    logic [15:0] cfg_t;
    amf_state_e fsm;
    logic        auto_on;
    logic        stopping;
    logic [4:0]  ratio_cnt;
    logic [31:0] dly_cnt;
    logic        dly_done;
    logic        need_t;
    logic        need_p;
    logic        cur_t;
    logic        set_auto;
    logic [2:0]  busy_cnt;
    logic        seed_t;
    logic        seed_p;
    amf_pair_s   filt;
    logic [4:0]  wr;
    logic [4:0]  rd;
    logic [5:0]  count;
    logic        flag_full;
    logic        flag_thr;
    logic        adc_start;
    logic        refused;
    logic        svc_ok;
    logic        busy;
    logic [2:0]  osc_sync;
    logic        osc_lvl;
  } amf_state_s;
endpackage : amf_pkg

// ### rtl/amf_auto_measure.sv
// measurement scheduler, moving-average filter and 32-pair result fifo
`timescale 1ns/1ps
`include "amf_consts.svh"

// Contract
// - operation word holds threshold 12:8, fifo mode 7:6, delay 3:0; resets zero.
// - delay codes map 5 ms up to 20 s; codes 13 and above give 60 s.
// - delay runs from end of one measurement set to start of next.
// - non-off delay starts auto mode at once unless both ratios are off.
// - auto mode ignores conversion and configuration write commands.
// - auto mode refuses service commands.
// - delay off stops new triggers, finishes running set, clears ratio counter.
// - each channel converts on events chosen by its ratio; last temperature reused.
// - events where neither channel is due convert nothing.
// - empty event still runs master clock briefly and flashes busy.
// - filter output is previous minus previous/k plus sample/k.
// - first result after filter enable seeds it; reseed only after off/on.
// - fifo holds 32 pairs, returned oldest first.
// - fifo mode 0 off, 1 stop when full, 2 or 3 overwrite oldest.
// - stop mode discards results once 32 unread pairs are stored.
// - overwrite mode keeps cycling; at most 31 pairs retrievable.
// - read cursor advances when a fifo read starts, even if aborted.
// - threshold n raises flag at n unread entries; zero never raises it.
// - fifo flags evaluated only at conversion end; storage continues to 32.
// - non-off fifo mode stores results until mode written back to off.
// - fifo mode off empties fifo and resets both cursors.
// - fifo stores results of single and automatic conversions.
// - ratio field 10:8 decodes off,1,2,4,8,16,32,32.
// - filter field 7:5 decodes off,2,4,8,16,32,32,32.
// - full and threshold flags stay set until host writes one to clear.
module amf_auto_measure #(
  parameter int unsigned TICKS_PER_MS = 1000000 / `AMF_OSC_PERIOD_NS
) (
  // clock, reset, oscillator pin
  input  wire logic               mclk_in,
  input  wire logic               rst_n_in,
  input  wire logic               osc_clk_in,
  // decoded host commands
  input  wire logic               op_wr_in,
  input  wire amf_pkg::amf_op_s   op_data_in,
  input  wire logic               conv_cmd_in,
  input  wire logic               conv_chan_in,
  input  wire logic               cfg_wr_in,
  input  wire logic               cfg_sel_in,
  input  wire logic [15:0]        cfg_data_in,
  input  wire logic               service_cmd_in,
  input  wire logic               fifo_rd_in,
  input  wire logic               flag_clr_in,
  input  wire logic [7:0]         flag_clr_data_in,
  // converter handshake
  input  wire logic               adc_done_in,
  input  wire logic [23:0]        adc_result_in,
  output logic                    adc_start_out,
  output logic                    adc_chan_out,
  // status and data
  output amf_pkg::amf_op_s        op_data_out,
  output amf_pkg::amf_pair_s      fifo_data_out,
  output logic                    fifo_valid_out,
  output logic [5:0]              fifo_count_out,
  output amf_pkg::amf_pair_s      result_out,
  output logic                    flag_full_out,
  output logic                    flag_thresh_out,
  output logic                    auto_active_out,
  output logic                    serial_busy_output_out,
  output logic                    mclk_en_out,
  output logic                    cmd_refused_out,
  output logic                    service_accept_out
);
  import amf_pkg::*;

  // -----------------------------------------------------------------
  // decode helpers
  // -----------------------------------------------------------------
  // ratio code to a counter mask; due when masked counter is zero
  function automatic logic [4:0] ratio_mask(input logic [2:0] code);
    unique case (code)
      3'h1:    ratio_mask = 5'h00;
      3'h2:    ratio_mask = 5'h01;
      3'h3:    ratio_mask = 5'h03;
      3'h4:    ratio_mask = 5'h07;
      3'h5:    ratio_mask = 5'h0F;
      default: ratio_mask = 5'h1F;
    endcase
  endfunction : ratio_mask

  function automatic logic is_due(input logic [15:0] cfg,
                                  input logic [4:0]  cnt);
    logic [2:0] r;
    r = cfg[`AMF_CFG_RATIO_HI:`AMF_CFG_RATIO_LO];
    is_due = (r != 3'h0) && ((cnt & ratio_mask(r)) == 5'h00);
  endfunction : is_due

  // filter code to shift, k = 2**shift
  function automatic logic [2:0] filt_shift(input logic [2:0] code);
    unique case (code)
      3'h1:    filt_shift = 3'h1;
      3'h2:    filt_shift = 3'h2;
      3'h3:    filt_shift = 3'h3;
      3'h4:    filt_shift = 3'h4;
      default: filt_shift = 3'h5;
    endcase
  endfunction : filt_shift

  // moving average step; unseeded or off passes the sample
  function automatic logic [23:0] filt_step(input logic [23:0] prev,
                                            input logic [23:0] x,
                                            input logic [2:0]  code,
                                            input logic        seeded);
    logic [2:0] s;
    s = filt_shift(code);
    if (code == 3'h0 || !seeded)
      filt_step = x;
    else
      filt_step = prev - (prev >> s) + (x >> s);
  endfunction : filt_step

  // delay code to oscillator ticks; long codes clamp to 60 s
  function automatic logic [31:0] dly_ticks(input logic [3:0] code);
    int unsigned ms;
    unique case (code)
      4'h1:    ms = `AMF_DLY1_MS;
      4'h2:    ms = `AMF_DLY2_MS;
      4'h3:    ms = `AMF_DLY3_MS;
      4'h4:    ms = `AMF_DLY4_MS;
      4'h5:    ms = `AMF_DLY5_MS;
      4'h6:    ms = `AMF_DLY6_MS;
      4'h7:    ms = `AMF_DLY7_MS;
      4'h8:    ms = `AMF_DLY8_MS;
      4'h9:    ms = `AMF_DLY9_MS;
      4'hA:    ms = `AMF_DLY10_MS;
      4'hB:    ms = `AMF_DLY11_MS;
      4'hC:    ms = `AMF_DLY12_MS;
      default: ms = `AMF_DLY_MAX_MS;
    endcase
    dly_ticks = 32'(ms * TICKS_PER_MS);
  endfunction : dly_ticks

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  amf_state_s st;
  amf_state_s next_st;
  amf_pair_s  mem [0:31];
  amf_pair_s  rd_data;
  logic       rd_valid;
  logic       push;
  logic       osc_tick;
  logic       due_t;
  logic       due_p;

  // -----------------------------------------------------------------
  // next-state logic
  // -----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.adc_start = 1'b0;
    next_st.refused = 1'b0;
    next_st.svc_ok = 1'b0;
    push = 1'b0;
    due_t = is_due(st.cfg_t, st.ratio_cnt);
    due_p = is_due(st.cfg_p, st.ratio_cnt);

    // oscillator edge: level moves only when stages two and three agree
    next_st.osc_sync = {st.osc_sync[1:0], osc_clk_in};
    osc_tick = (st.osc_sync[1] == st.osc_sync[2]) && st.osc_sync[2]
               && !st.osc_lvl;
    if (st.osc_sync[1] == st.osc_sync[2])
      next_st.osc_lvl = st.osc_sync[2];

    // delay timer counts only while idle between sets
    if (st.auto_on && st.fsm == AMF_IDLE && !st.dly_done && osc_tick) begin
      if (st.dly_cnt + 32'h1 >= dly_ticks(st.op.delay))
        next_st.dly_done = 1'b1;
      else
        next_st.dly_cnt = st.dly_cnt + 32'h1;
    end

    // operation word write
    if (op_wr_in) begin
      next_st.op = op_data_in;
      if (op_data_in.mode == `AMF_MODE_OFF) begin
        next_st.wr = 5'h00;
        next_st.rd = 5'h00;
        next_st.count = 6'h00;
      end
      if (op_data_in.delay == 4'h0) begin
        if (st.auto_on)
          next_st.stopping = 1'b1;
      end else if (!st.auto_on &&
                   (st.cfg_p[`AMF_CFG_RATIO_HI:`AMF_CFG_RATIO_LO] != 3'h0 ||
                    st.cfg_t[`AMF_CFG_RATIO_HI:`AMF_CFG_RATIO_LO] != 3'h0))
      begin
        next_st.auto_on = 1'b1;
        next_st.stopping = 1'b0;
        next_st.dly_done = 1'b1;
        next_st.dly_cnt = 32'h0;
      end
    end

    // configuration write, locked out in auto mode
    if (cfg_wr_in) begin
      if (st.auto_on) begin
        next_st.refused = 1'b1;
      end else if (cfg_sel_in) begin
        next_st.cfg_t = cfg_data_in;
        if (cfg_data_in[`AMF_CFG_FILT_HI:`AMF_CFG_FILT_LO] == 3'h0)
          next_st.seed_t = 1'b0;
      end else begin
        next_st.cfg_p = cfg_data_in;
        if (cfg_data_in[`AMF_CFG_FILT_HI:`AMF_CFG_FILT_LO] == 3'h0)
          next_st.seed_p = 1'b0;
      end
    end

    // service class commands
    if (service_cmd_in) begin
      if (st.auto_on)
        next_st.refused = 1'b1;
      else
        next_st.svc_ok = 1'b1;
    end
    if (conv_cmd_in && st.auto_on)
      next_st.refused = 1'b1;

    // fifo read: cursor moves as the read starts
    // a same-cycle mode-off write has already emptied it: no underflow
    if (fifo_rd_in && next_st.count != 6'h00) begin
      next_st.rd = st.rd + 5'h01;
      next_st.count = next_st.count - 6'h01;
    end

    // sticky flags: write one to clear, later set wins
    if (flag_clr_in) begin
      if (flag_clr_data_in[`AMF_FLAG_FULL])
        next_st.flag_full = 1'b0;
      if (flag_clr_data_in[`AMF_FLAG_THR])
        next_st.flag_thr = 1'b0;
    end

    // scheduler
    unique case (st.fsm)
      AMF_IDLE: begin
        if (st.stopping) begin
          next_st.auto_on = 1'b0;
          next_st.stopping = 1'b0;
          next_st.ratio_cnt = 5'h00;
        end else if (st.auto_on && st.dly_done) begin
          next_st.dly_done = 1'b0;
          next_st.dly_cnt = 32'h0;
          if (!due_t && !due_p) begin
            next_st.fsm = AMF_SKIP;
            next_st.busy_cnt = 3'(`AMF_BUSY_CYC);
            next_st.ratio_cnt = st.ratio_cnt + 5'h01;
          end else begin
            next_st.need_t = due_t;
            next_st.need_p = due_p;
            next_st.cur_t = due_t;
            next_st.set_auto = 1'b1;
            next_st.adc_start = 1'b1;
            next_st.fsm = AMF_CONV;
          end
        end else if (conv_cmd_in && !st.auto_on) begin
          next_st.need_t = conv_chan_in;
          next_st.need_p = !conv_chan_in;
          next_st.cur_t = conv_chan_in;
          next_st.set_auto = 1'b0;
          next_st.adc_start = 1'b1;
          next_st.fsm = AMF_CONV;
        end
      end
      AMF_CONV: begin
        if (adc_done_in) begin
          if (st.cur_t) begin
            next_st.filt.temp = filt_step(st.filt.temp, adc_result_in,
              st.cfg_t[`AMF_CFG_FILT_HI:`AMF_CFG_FILT_LO], st.seed_t);
            next_st.seed_t =
              st.cfg_t[`AMF_CFG_FILT_HI:`AMF_CFG_FILT_LO] != 3'h0;
            next_st.need_t = 1'b0;
          end else begin
            next_st.filt.pres = filt_step(st.filt.pres, adc_result_in,
              st.cfg_p[`AMF_CFG_FILT_HI:`AMF_CFG_FILT_LO], st.seed_p);
            next_st.seed_p =
              st.cfg_p[`AMF_CFG_FILT_HI:`AMF_CFG_FILT_LO] != 3'h0;
            next_st.need_p = 1'b0;
          end
          if (st.cur_t && st.need_p) begin
            next_st.cur_t = 1'b0;
            next_st.adc_start = 1'b1;
          end else begin
            // set complete: store pair, restart the delay timer
            next_st.fsm = AMF_IDLE;
            next_st.dly_cnt = 32'h0;
            if (st.set_auto)
              next_st.ratio_cnt = st.ratio_cnt + 5'h01;
            push = (st.op.mode != `AMF_MODE_OFF) &&
                   !(op_wr_in && op_data_in.mode == `AMF_MODE_OFF);
          end
        end
      end
      AMF_SKIP: begin
        next_st.busy_cnt = st.busy_cnt - 3'h1;
        if (st.busy_cnt == 3'h1)
          next_st.fsm = AMF_IDLE;
      end
      default: next_st.fsm = AMF_IDLE;
    endcase

    // fifo store; flags only looked at when a set completes
    if (push) begin
      if (st.op.mode == `AMF_MODE_FULL) begin
        if (next_st.count != `AMF_FIFO_DEPTH) begin
          next_st.wr = st.wr + 5'h01;
          next_st.count = next_st.count + 6'h01;
        end
      end else begin
        next_st.wr = st.wr + 5'h01;
        if (next_st.count == `AMF_FIFO_UPD_MAX)
          next_st.rd = next_st.rd + 5'h01;
        else
          next_st.count = next_st.count + 6'h01;
      end
      if (next_st.count == `AMF_FIFO_DEPTH)
        next_st.flag_full = 1'b1;
      if (st.op.thr != 5'h00 && next_st.count >= {1'b0, st.op.thr})
        next_st.flag_thr = 1'b1;
    end

    next_st.busy = next_st.fsm != AMF_IDLE;
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      st <= '0;
      st.op <= `AMF_OP_RESET;
      st.fsm <= AMF_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // pair storage; a discarded push in stop mode leaves wr unmoved
  always_ff @(posedge mclk_in) begin
    if (push && next_st.wr != st.wr)
      mem[st.wr] <= next_st.filt;
  end

  // read port, oldest entry first
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      rd_data <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= fifo_rd_in && st.count != 6'h00;
      if (fifo_rd_in && st.count != 6'h00)
        rd_data <= mem[st.rd];
    end
  end

  // outputs, all from flops
  assign adc_start_out          = st.adc_start;
  assign adc_chan_out           = st.cur_t;
  assign op_data_out            = st.op;
  assign fifo_data_out          = rd_data;
  assign fifo_valid_out         = rd_valid;
  assign fifo_count_out         = st.count;
  assign result_out             = st.filt;
  assign flag_full_out          = st.flag_full;
  assign flag_thresh_out        = st.flag_thr;
  assign auto_active_out        = st.auto_on;
  assign serial_busy_output_out = st.busy;
  assign mclk_en_out            = st.busy;
  assign cmd_refused_out        = st.refused;
  assign service_accept_out     = st.svc_ok;

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_stop_req;
    op_wr_in && op_data_in.delay == 4'h0 && st.auto_on;
  endsequence
  sequence s_set_over;
    st.fsm == AMF_IDLE ##1 st.fsm == AMF_IDLE;
  endsequence

  a_cfg_lockout: assert property (
    cfg_wr_in && st.auto_on |=> cmd_refused_out && $stable(st.cfg_p)
  ) else $error("config write taken in auto mode");
  a_service_refuse: assert property (
    service_cmd_in && st.auto_on |=> cmd_refused_out && !service_accept_out
  ) else $error("service command not refused");
  a_stop_finish: assert property (
    s_stop_req ##0 s_set_over |=> !st.auto_on && st.ratio_cnt == 5'h00
  ) else $error("auto stop did not clear ratio counter");
  a_fifo_bound: assert property (
    st.count <= `AMF_FIFO_DEPTH &&
    (st.op.mode[1] -> st.count <= `AMF_FIFO_UPD_MAX)
  ) else $error("fifo count out of range");
  a_full_discard: assert property (
    push && st.op.mode == `AMF_MODE_FULL && st.count == `AMF_FIFO_DEPTH
    && !fifo_rd_in |=> st.count == `AMF_FIFO_DEPTH && $stable(st.wr)
  ) else $error("stop mode stored past full");
  a_fifo_off: assert property (
    op_wr_in && op_data_in.mode == `AMF_MODE_OFF |=>
    st.count == 6'h00 && st.rd == 5'h00 && st.wr == 5'h00
  ) else $error("fifo not emptied on mode off");
  a_read_cursor: assert property (
    fifo_rd_in && st.count != 6'h00 && !push &&
    !(op_wr_in && op_data_in.mode == `AMF_MODE_OFF) |=>
    st.rd == $past(st.rd) + 5'h01 && fifo_valid_out
  ) else $error("read cursor did not advance");
  a_thresh_zero: assert property (
    st.op.thr == 5'h00 && !st.flag_thr && !op_wr_in |=> !st.flag_thr
  ) else $error("threshold flag raised with threshold off");
  a_flag_sticky: assert property (
    st.flag_full && !flag_clr_in |=> st.flag_full
  ) else $error("full flag dropped without clear");
  a_skip_busy: assert property (
    st.fsm == AMF_IDLE ##1 st.fsm == AMF_SKIP |->
    serial_busy_output_out [*5] ##1 !serial_busy_output_out
  ) else $error("empty event busy flash wrong length");

endmodule : amf_auto_measure

// ### testbench/amf_adc_model.sv
// converter model answering start pulses after a short or long delay
`timescale 1ns/1ps
module amf_adc_model (
  // clock, reset, latency choice
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        slow_in,
  // start handshake from the core
  input  wire logic        start_in,
  input  wire logic        chan_in,
  output logic             done_out,
  output logic [23:0]      result_out
);
  logic [3:0]  wait_cnt;
  logic [23:0] seq;
  logic        chan_q;
  // result valid only with done; otherwise it toggles so a stale read shows
  always_ff @(posedge clk_in) begin
    done_out   <= 1'b0;
    result_out <= ~result_out;
    if (!rst_n_in) begin
      wait_cnt <= 4'h0;
      seq      <= 24'h000000;
    end else if (start_in) begin
      wait_cnt <= slow_in ? 4'h6 : 4'h1;
      chan_q   <= chan_in;
    end else if (wait_cnt == 4'h1) begin
      done_out   <= 1'b1;
      result_out <= {chan_q, seq[22:0]};
      seq        <= seq + 24'h000001;
      wait_cnt   <= 4'h0;
    end else if (wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
    end
  end
endmodule : amf_adc_model

// ### testbench/amf_auto_measure_tb_top.sv
// self-checking bench for the measurement, filter and fifo core
`timescale 1ns/1ps
module amf_auto_measure_tb_top;
  import amf_pkg::*;
  logic mclk_in = 0, rst_n_in = 0, osc = 0, slow = 0, done, start, achan;
  logic op_wr = 0, conv = 0, chan = 0, cfg_wr = 0, svc = 0, rd = 0, clr = 0;
  logic cfg_sel = 0, fv, ff, ft, aa, busy, mce, refd, sacc;
  logic [15:0] cfg_d = 0;
  logic [7:0]  clr_d = 0;
  logic [23:0] res;
  logic [5:0]  cnt;
  logic [23:0] smp, pv;
  amf_op_s     op_d = 0, op_q;
  amf_pair_s   fd, ro;
  int          error_cnt = 0, total_checks = 0, g;
  // free-running core and oscillator clocks, oscillator offset in phase
  always #10 mclk_in = ~mclk_in;
  initial begin
    #7;
    forever #80 osc = ~osc;
  end
  amf_auto_measure #(.TICKS_PER_MS(2)) dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .osc_clk_in(osc),
    .op_wr_in(op_wr), .op_data_in(op_d), .conv_cmd_in(conv),
    .conv_chan_in(chan), .cfg_wr_in(cfg_wr), .cfg_sel_in(cfg_sel),
    .cfg_data_in(cfg_d), .service_cmd_in(svc), .fifo_rd_in(rd),
    .flag_clr_in(clr), .flag_clr_data_in(clr_d), .adc_done_in(done),
    .adc_result_in(res), .adc_start_out(start), .adc_chan_out(achan),
    .op_data_out(op_q), .fifo_data_out(fd), .fifo_valid_out(fv),
    .fifo_count_out(cnt), .result_out(ro), .flag_full_out(ff),
    .flag_thresh_out(ft), .auto_active_out(aa),
    .serial_busy_output_out(busy), .mclk_en_out(mce),
    .cmd_refused_out(refd), .service_accept_out(sacc));
  amf_adc_model adc (.clk_in(mclk_in), .rst_n_in(rst_n_in),
    .slow_in(slow), .start_in(start), .chan_in(achan), .done_out(done),
    .result_out(res));
  // sample handed over, taken at the edge where the core takes it
  always @(posedge mclk_in)
    if (done === 1'b1) smp <= res;
  // moving average step with k = 2**s
  function automatic logic [23:0] fexp(input logic [23:0] p, x,
                                       input int s);
    return p - (p >> s) + (x >> s);
  endfunction : fexp
  // one comparison, counted
  task automatic chk(input string nm, input logic [47:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one-cycle command strobe; returns once its answer has landed
  task automatic hit(input int k);
    @(negedge mclk_in);
    case (k)
      0: op_wr = 1;
      1: conv = 1;
      2: cfg_wr = 1;
      3: svc = 1;
      4: rd = 1;
      default: clr = 1;
    endcase
    @(negedge mclk_in);
    {op_wr, conv, cfg_wr, svc, rd, clr} = '0;
  endtask : hit
  task automatic wr_op(input logic [4:0] t, input logic [1:0] m,
                       input logic [3:0] d);
    op_d = {3'h0, t, m, 2'h0, d};
    hit(0);
  endtask : wr_op
  // bounded wait for a busy period to start and end
  task automatic wait_idle;
    bit seen;
    bit fin;
    seen = 0;
    fin = 0;
    for (int i = 0; i < 200; i++) begin
      @(negedge mclk_in);
      if (busy === 1'b1) seen = 1;
      if (seen && busy === 1'b0) begin
        fin = 1;
        break;
      end
    end
    chk("busy ended", fin, 1);
    @(negedge mclk_in);
  endtask : wait_idle
  task automatic cv(input logic c);
    chan = c;
    slow = $urandom % 2;
    hit(1);
    wait_idle();
  endtask : cv
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  // watchdog sized well past the expected run length
  initial begin
    #300000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h2676ddc9));
    repeat (16) @(negedge mclk_in);
    rst_n_in = 1;
    chk("op reset", op_q, 0);
    chk("count reset", cnt, 0);
    wr_op(5'($urandom), 2'h0, 4'h3);
    chk("op readback", op_q, op_d);
    repeat (40) @(negedge mclk_in);
    chk("no auto start", aa, 0);
    wr_op(5'h05, 2'h1, 4'h0);
    $display("test register done");
    cv(1);
    for (int i = 0; i < 33; i++) begin
      cv(0);
      if (i == 2) chk("thr early", ft, 0);
      if (i == 3) chk("thr at n", ft, 1);
    end
    chk("full count", cnt, 6'h20);
    chk("full flag", ff, 1);
    hit(4);
    chk("read valid", fv, 1);
    chk("oldest temp", fd.temp, 24'h800000);
    hit(4);
    chk("second pair", fd, {24'h800000, 24'h000001});
    chk("count after read", cnt, 6'h1E);
    clr_d = 8'h04;
    hit(5);
    chk("full cleared", ff, 0);
    chk("thr kept", ft, 1);
    wr_op(5'h00, 2'h0, 4'h0);
    chk("off empties", cnt, 0);
    hit(4);
    chk("empty read", fv, 0);
    wr_op(5'h00, 2'h2 | 2'($urandom % 2), 4'h0);
    for (int i = 0; i < 33; i++) cv(0);
    chk("update max", cnt, 6'h1F);
    chk("no full flag", ff, 0);
    wr_op(5'h00, 2'h0, 4'h0);
    $display("test fifo done");
    hit(3);
    chk("svc accepted", {refd, sacc}, 2'b01);
    cfg_d = 16'h0020;
    hit(2);
    cv(0);
    pv = smp;
    chk("filter seed", ro.pres, pv);
    cv(0);
    pv = fexp(pv, smp, 1);
    chk("filter k2", ro.pres, pv);
    cfg_d = 16'h00C0;
    hit(2);
    cv(0);
    pv = fexp(pv, smp, 5);
    chk("filter k32", ro.pres, pv);
    cfg_d = 16'h0000;
    hit(2);
    cfg_d = 16'h0020;
    hit(2);
    cv(0);
    chk("filter reseed", ro.pres, smp);
    $display("test filter done");
    cfg_d = 16'h0100;
    hit(2);
    wr_op(5'h00, 2'h1, 4'h1);
    chk("auto on", aa, 1);
    wait_idle();
    chk("auto push", cnt != 0, 1);
    for (g = 0; g < 300 && start !== 1'b1; g++) @(negedge mclk_in);
    chk("set gap", g >= 72 && g <= 96, 1);
    hit(1);
    chk("conv refused", refd, 1);
    hit(2);
    chk("cfg refused", refd, 1);
    hit(3);
    chk("svc refused", {refd, sacc}, 2'b10);
    wr_op(5'h00, 2'h1, 4'h0);
    for (g = 0; g < 300 && aa !== 1'b0; g++) @(negedge mclk_in);
    chk("auto stops", aa, 0);
    cfg_sel = 1;
    cfg_d = 16'h0300;
    hit(2);
    cfg_sel = 0;
    cfg_d = 16'h0200;
    hit(2);
    wr_op(5'h00, 2'h0, 4'h1);
    for (g = 0; g < 9 && start !== 1'b1; g++) @(negedge mclk_in);
    chk("temp first", achan, 1);
    wait_idle();
    for (g = 0; g < 300 && busy !== 1'b1; g++) @(negedge mclk_in);
    for (g = 0; g < 9 && busy === 1'b1; g++) begin
      chk("skip quiet", {start, mce}, 2'b01);
      @(negedge mclk_in);
    end
    chk("skip flash", g, 5);
    for (g = 0; g < 300 && start !== 1'b1; g++) @(negedge mclk_in);
    chk("pres only", achan, 0);
    wr_op(5'h00, 2'h0, 4'h0);
    for (g = 0; g < 300 && aa !== 1'b0; g++) @(negedge mclk_in);
    chk("auto stops again", aa, 0);
    $display("test auto done");
    end_of_test();
  end
endmodule : amf_auto_measure_tb_top
